// >>> common/tdcm_map.svh
// Constants for the hit trigger matching block: timing, register map, fields and word codes.
//
// Contract
// R1 - Continuous mode writes only hit words, time order
// R2 - Hits under 25 ns apart may misorder
// R3 - Overflow: error word, full flag, data lost
// R4 - Match trigger tags against buffered hits
// R5 - Four window parameters in 25 ns steps
// R6 - Window offset is signed from trigger
// R7 - Triggers delayed 40 cycles before matching
// R8 - Search extends past window, default eight cycles
// R9 - Reject old hits when no trigger waits
// R10 - Software programs reject margin at least one
// R11 - Optional header and trailer frame each event
// R12 - Hit times absolute or window relative
// R13 - Hit limit first come; error word if dropped
// R14 - Matching errors produce an error flag word
// R15 - Hit in overlapping windows reported each time
// R16 - Overflow sets trailer full bit
// R17 - Window width and offset are 12 bits
// R18 - Software: early window offset negative, bounded
// R19 - Software: width plus offset at most 40
// R20 - Time counter 21 bits, wraps at full scale
// R21 - 32-bit tick counter latched per trigger
// R22 - Empty events may be suppressed
// R23 - Bunch reset loads time counter offsets
// R24 - Event reset loads event id offset
`ifndef TDCM_MAP_SVH
`define TDCM_MAP_SVH
`define TDCM_CLK_NS      6'd4
`define TDCM_TICK_NS     6'd25
`define TDCM_TRIG_DELAY  12'd40
`define TDCM_COARSE_W    11
`define TDCM_FINE_W      10
`define TDCM_A_CTRL      8'h00
`define TDCM_A_WIN       8'h04
`define TDCM_A_MARGIN    8'h08
`define TDCM_A_LIMIT     8'h0c
`define TDCM_A_TOFFS     8'h10
`define TDCM_A_EOFFS     8'h14
`define TDCM_A_STATUS    8'h18
`define TDCM_A_LONG_TRIGGER_TIMESTAMP      8'h1c
`define TDCM_C_TRIG      0
`define TDCM_C_HDR       1
`define TDCM_C_TRL       2
`define TDCM_C_REL       3
`define TDCM_C_SUPP      4
`define TDCM_C_LONG_TRIGGER_TIMESTAMP      5
`define TDCM_RST_WIDTH   12'h014
`define TDCM_RST_OFFSET  12'hfd8
`define TDCM_RST_EXTRA   12'h008
`define TDCM_RST_REJECT  12'h001
`define TDCM_W_DATA      5'h00
`define TDCM_W_HEAD      5'h01
`define TDCM_W_TRAIL     5'h03
`define TDCM_W_ERR       5'h04
`define TDCM_W_LONG_TRIGGER_TIMESTAMP      5'h11
`endif

// >>> common/tdcm_pkg.sv
// Types shared by the hit trigger matching block.
`default_nettype none
`include "tdcm_map.svh"
package tdcm_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_FLUSH, ST_ERR, ST_TRAIL} tdcm_state_e;
  typedef struct packed {
    logic        par;
    logic [11:0] tag;
    logic [4:0]  chan;
    logic [20:0] tim;
  } tdcm_hit_s;
endpackage : tdcm_pkg
`default_nettype wire

// >>> logic/tdcm_match.sv
// Hit selection and event building with an APB register slave.
`default_nettype none
`include "tdcm_map.svh"
module tdcm_match
  import tdcm_pkg::*;
#(
  parameter int HB_AW = 8,
  parameter int TF_AW = 4,
  parameter int OF_AW = 8
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        hit_valid_i,
  input  wire logic [4:0]  hit_chan_i,
  input  wire logic [9:0]  hit_fine_i,
  input  wire logic        trig_i,
  input  wire logic        bcr_i,
  input  wire logic        ecr_i,
  output logic             out_valid_o,
  output logic      [31:0] out_data_o,
  input  wire logic        out_ready_i,
  output logic             full_o
);

  function automatic logic [31:0] mkword(input logic [4:0] t, input logic [26:0] p);
    return {t, p};
  endfunction : mkword

  // ----------------------------------------------------------------
  // Cycle tick
  // ----------------------------------------------------------------
  // A 250 MHz clock has no whole divide to 25 ns, so a phase accumulator
  // spaces ticks six or seven cycles apart with an exact long-run period.
  logic [5:0] acc_r;
  logic       tick_r;
  wire  [5:0] acc_sum = acc_r + `TDCM_CLK_NS;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_r  <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= acc_sum >= `TDCM_TICK_NS; // R5
      acc_r  <= (acc_sum >= `TDCM_TICK_NS) ? acc_sum - `TDCM_TICK_NS : acc_sum;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0]  ctrl_r;
  logic [11:0] win_w_r, win_off_r, extra_r, rejm_r, toff_r, eoff_r;
  logic [10:0] coff_r;
  logic [7:0]  limit_r;
  logic        full_r, hovf_r, tovf_r, par_r;
  logic [31:0] long_trigger_timestamp_r;
  logic        pready_r, pslverr_r;
  logic [31:0] prdata_r;
  wire trig_mode = ctrl_r[`TDCM_C_TRIG];
  wire wr_acc    = psel_i & penable_i & pready_r & pwrite_i;
  wire setup     = psel_i & ~penable_i;
  logic hovf_ev, tovf_ev, par_ev, full_ev;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r    <= 6'h00;
      win_w_r   <= `TDCM_RST_WIDTH;
      win_off_r <= `TDCM_RST_OFFSET;
      extra_r   <= `TDCM_RST_EXTRA;
      rejm_r    <= `TDCM_RST_REJECT;
      limit_r   <= 8'h00;
      coff_r    <= 11'h000;
      toff_r    <= 12'h000;
      eoff_r    <= 12'h000;
    end else if (wr_acc) begin
      case (paddr_i)
        `TDCM_A_CTRL:   ctrl_r <= pwdata_i[5:0];
        `TDCM_A_WIN: begin
          win_w_r   <= pwdata_i[11:0]; // R17
          win_off_r <= pwdata_i[27:16];
        end
        `TDCM_A_MARGIN: begin
          extra_r <= pwdata_i[11:0];
          rejm_r  <= pwdata_i[27:16];
        end
        `TDCM_A_LIMIT:  limit_r <= pwdata_i[7:0];
        `TDCM_A_TOFFS: begin
          toff_r <= pwdata_i[11:0];
          coff_r <= pwdata_i[26:16];
        end
        `TDCM_A_EOFFS:  eoff_r <= pwdata_i[11:0];
        default: ;
      endcase
    end
  end

  // Status bits clear by writing one; a new event in the same cycle wins.
  wire st_clr = wr_acc && paddr_i == `TDCM_A_STATUS;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      full_r <= 1'b0;
      hovf_r <= 1'b0;
      tovf_r <= 1'b0;
      par_r  <= 1'b0;
    end else begin
      full_r <= full_ev | (full_r & ~(st_clr & pwdata_i[0])); // R3
      hovf_r <= hovf_ev | (hovf_r & ~(st_clr & pwdata_i[1]));
      tovf_r <= tovf_ev | (tovf_r & ~(st_clr & pwdata_i[2]));
      par_r  <= par_ev  | (par_r  & ~(st_clr & pwdata_i[3]));
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      if (setup) begin
        case (paddr_i)
          `TDCM_A_CTRL:   prdata_r <= {26'h0, ctrl_r};
          `TDCM_A_WIN:    prdata_r <= {4'h0, win_off_r, 4'h0, win_w_r};
          `TDCM_A_MARGIN: prdata_r <= {4'h0, rejm_r, 4'h0, extra_r};
          `TDCM_A_LIMIT:  prdata_r <= {24'h0, limit_r};
          `TDCM_A_TOFFS:  prdata_r <= {5'h0, coff_r, 4'h0, toff_r};
          `TDCM_A_EOFFS:  prdata_r <= {20'h0, eoff_r};
          `TDCM_A_STATUS: prdata_r <= {28'h0, par_r, tovf_r, hovf_r, full_r};
          `TDCM_A_LONG_TRIGGER_TIMESTAMP:   prdata_r <= long_trigger_timestamp_r;
          default:        pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Time counters
  // ----------------------------------------------------------------
  logic [10:0] coarse_r;
  logic [11:0] tag_r, rej_r, evid_r;
  logic        tf_push;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      coarse_r <= 11'h000;
      tag_r    <= 12'h000;
      rej_r    <= 12'h000;
      long_trigger_timestamp_r   <= 32'h0;
    end else begin
      if (tick_r)
        long_trigger_timestamp_r <= long_trigger_timestamp_r + 32'h1; // R21
      if (bcr_i) begin
        coarse_r <= coff_r; // R23
        tag_r    <= toff_r;
        rej_r    <= toff_r - rejm_r;
      end else if (tick_r) begin
        coarse_r <= coarse_r + 11'h001; // R20
        tag_r    <= tag_r + 12'h001;
        rej_r    <= rej_r + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      evid_r <= 12'h000;
    else if (ecr_i)
      evid_r <= eoff_r; // R24
    else if (trig_i && trig_mode)
      evid_r <= evid_r + 12'h001;
  end

  // ----------------------------------------------------------------
  // Hit stage buffer and trigger FIFO
  // ----------------------------------------------------------------
  tdcm_hit_s hb_mem [2**HB_AW];
  logic [HB_AW-1:0] wp_r, rp_r, sp_r, send_r;
  tdcm_hit_s new_hit;
  wire hb_full  = wp_r + HB_AW'(1) == rp_r;
  wire hb_empty = wp_r == rp_r;
  always_comb begin
    new_hit      = '0;
    new_hit.tag  = tag_r;
    new_hit.chan = hit_chan_i;
    new_hit.tim  = {coarse_r, hit_fine_i};
    new_hit.par  = ^{tag_r, hit_chan_i, coarse_r, hit_fine_i};
  end
  assign hovf_ev = trig_mode & hit_valid_i & hb_full;

  logic [11:0] tf_tag [2**TF_AW];
  logic [31:0] tf_ett [2**TF_AW];
  logic [11:0] tf_eid [2**TF_AW];
  logic [TF_AW:0] tf_wp_r, tf_rp_r;
  wire [TF_AW-1:0] tf_wi = tf_wp_r[TF_AW-1:0];
  wire [TF_AW-1:0] tf_ri = tf_rp_r[TF_AW-1:0];
  wire tf_empty = tf_wp_r == tf_rp_r;
  wire tf_full  = tf_wp_r == {~tf_rp_r[TF_AW], tf_rp_r[TF_AW-1:0]};
  assign tf_push = trig_i & trig_mode & ~tf_full;
  assign tovf_ev = trig_i & trig_mode & tf_full;
  always_ff @(posedge clk_i) begin
    if (trig_mode && hit_valid_i && !hb_full)
      hb_mem[wp_r] <= new_hit;
    if (tf_push) begin
      tf_tag[tf_wi] <= tag_r;
      tf_ett[tf_wi] <= long_trigger_timestamp_r; // R21
      tf_eid[tf_wi] <= evid_r;
    end
  end

  // Matching waits until the trigger has aged by the fixed delay, so a
  // window that straddles or follows the trigger is already stored.
  tdcm_state_e st_r;
  wire [11:0] age   = tag_r - tf_tag[tf_ri];
  wire start_ev = st_r == ST_IDLE && trig_mode && !tf_empty && age >= `TDCM_TRIG_DELAY; // R7
  // Old hits go only while no trigger waits, judged by the reject counter.
  tdcm_hit_s  rp_hit;
  assign rp_hit = hb_mem[rp_r];
  wire [11:0] rej_age = rej_r - rp_hit.tag;
  wire reject = st_r == ST_IDLE && tf_empty && !hb_empty && !rej_age[11] && rej_age != 12'h0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r    <= '0;
      rp_r    <= '0;
      tf_wp_r <= '0;
      tf_rp_r <= '0;
    end else begin
      if (trig_mode && hit_valid_i && !hb_full)
        wp_r <= wp_r + HB_AW'(1);
      if (reject)
        rp_r <= rp_r + HB_AW'(1); // R9
      if (tf_push)
        tf_wp_r <= tf_wp_r + (TF_AW+1)'(1);
      if (start_ev)
        tf_rp_r <= tf_rp_r + (TF_AW+1)'(1); // R4
    end
  end

  // ----------------------------------------------------------------
  // Event builder
  // ----------------------------------------------------------------
  logic [11:0] ev_tag_r, ev_eid_r, win_st_r, cnt_r;
  logic [31:0] ev_ett_r;
  logic [7:0]  lim_r;
  logic        hdr_done_r, ett_done_r, e_hovf_r, e_tovf_r, e_par_r, e_lim_r;
  logic        of_push, of_full;
  logic [31:0] of_word;
  tdcm_hit_s   sp_hit;
  assign sp_hit = hb_mem[sp_r];
  wire [11:0] diff   = sp_hit.tag - win_st_r; // R6
  wire in_win = diff < win_w_r;
  // Hits written out of order can trail the window by the search margin.
  wire beyond = !diff[11] && diff >= win_w_r + extra_r; // R8
  wire lim_hit = limit_r != 8'h00 && lim_r >= limit_r;
  wire bad_par = ^sp_hit;
  assign par_ev = st_r == ST_SCAN && sp_r != send_r && bad_par;
  wire any_err  = e_hovf_r | e_tovf_r | e_par_r | e_lim_r;
  wire [20:0] rep_time = ctrl_r[`TDCM_C_REL] ? {diff[10:0], sp_hit.tim[9:0]} : sp_hit.tim; // R12
  wire [31:0] w_head = mkword(`TDCM_W_HEAD, {3'h0, ev_eid_r, ev_tag_r});
  wire [31:0] w_ett  = mkword(`TDCM_W_LONG_TRIGGER_TIMESTAMP, ev_ett_r[31:5]);
  wire need_hdr = ctrl_r[`TDCM_C_HDR] && !hdr_done_r;
  wire need_ett = ctrl_r[`TDCM_C_LONG_TRIGGER_TIMESTAMP] && !ett_done_r;
  wire scan_wr  = st_r == ST_SCAN && sp_r != send_r && in_win && !lim_hit && !beyond;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r       <= ST_IDLE;
      sp_r       <= '0;
      send_r     <= '0;
      ev_tag_r   <= 12'h0;
      ev_eid_r   <= 12'h0;
      ev_ett_r   <= 32'h0;
      win_st_r   <= 12'h0;
      cnt_r      <= 12'h0;
      lim_r      <= 8'h0;
      hdr_done_r <= 1'b0;
      ett_done_r <= 1'b0;
      e_lim_r    <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: if (start_ev) begin
          ev_tag_r   <= tf_tag[tf_ri];
          ev_eid_r   <= tf_eid[tf_ri];
          ev_ett_r   <= tf_ett[tf_ri];
          win_st_r   <= tf_tag[tf_ri] + win_off_r; // R6
          sp_r       <= rp_r; // R15
          send_r     <= wp_r;
          cnt_r      <= 12'h0;
          lim_r      <= 8'h0;
          hdr_done_r <= 1'b0;
          ett_done_r <= 1'b0;
          e_lim_r    <= 1'b0;
          st_r       <= ST_SCAN;
        end
        ST_SCAN: begin
          if (sp_r == send_r || beyond) begin
            st_r <= ST_FLUSH;
          end else if (scan_wr) begin
            if (!of_full) begin
              if (need_hdr)
                hdr_done_r <= 1'b1; // R11
              else if (need_ett)
                ett_done_r <= 1'b1;
              else begin
                cnt_r <= cnt_r + 12'h001;
                lim_r <= lim_r + 8'h01; // R13
                sp_r  <= sp_r + HB_AW'(1);
              end
            end
          end else begin
            if (in_win && lim_hit)
              e_lim_r <= 1'b1; // R13
            sp_r <= sp_r + HB_AW'(1);
          end
        end
        ST_FLUSH: begin
          if (cnt_r == 12'h0 && ctrl_r[`TDCM_C_SUPP] && !any_err)
            st_r <= ST_IDLE; // R22
          else if (!of_full && need_hdr)
            hdr_done_r <= 1'b1;
          else if (!of_full && need_ett)
            ett_done_r <= 1'b1;
          else if (!need_hdr && !need_ett)
            st_r <= ST_ERR;
        end
        ST_ERR:   if (!of_full || !any_err) st_r <= ST_TRAIL; // R14
        ST_TRAIL: if (!of_full || !ctrl_r[`TDCM_C_TRL]) st_r <= ST_IDLE;
        default:  st_r <= ST_IDLE;
      endcase
    end
  end

  // Per-event error flags; an error in the start cycle still counts.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      e_hovf_r <= 1'b0;
      e_tovf_r <= 1'b0;
      e_par_r  <= 1'b0;
    end else begin
      e_hovf_r <= hovf_ev | (e_hovf_r & ~start_ev);
      e_tovf_r <= tovf_ev | (e_tovf_r & ~start_ev);
      e_par_r  <= par_ev  | (e_par_r  & ~start_ev);
    end
  end

  // ----------------------------------------------------------------
  // Readout FIFO and write mux
  // ----------------------------------------------------------------
  logic cerr_r;
  wire  cont_hit = !trig_mode && hit_valid_i;
  assign full_ev = cont_hit && of_full; // R3
  always_comb begin
    of_push = 1'b0;
    of_word = 32'h0;
    if (!trig_mode) begin
      if (cerr_r) begin
        of_push = !of_full; // R3
        of_word = mkword(`TDCM_W_ERR, 27'h1);
      end else if (cont_hit) begin
        of_push = !of_full; // R1
        of_word = mkword(`TDCM_W_DATA, {1'b0, hit_chan_i, coarse_r, hit_fine_i}); // R2
      end
    end else begin
      case (st_r)
        ST_SCAN: begin
          of_push = scan_wr && !of_full;
          of_word = need_hdr ? w_head : need_ett ? w_ett :
                    mkword(`TDCM_W_DATA, {1'b0, sp_hit.chan, rep_time});
        end
        ST_FLUSH: begin
          of_push = !of_full && (need_hdr || need_ett) &&
                    !(cnt_r == 12'h0 && ctrl_r[`TDCM_C_SUPP] && !any_err);
          of_word = need_hdr ? w_head : w_ett;
        end
        ST_ERR: begin
          of_push = !of_full && any_err; // R14
          of_word = mkword(`TDCM_W_ERR, {23'h0, e_lim_r, e_par_r, e_tovf_r, e_hovf_r});
        end
        ST_TRAIL: begin
          of_push = !of_full && ctrl_r[`TDCM_C_TRL]; // R11
          of_word = mkword(`TDCM_W_TRAIL, {e_hovf_r | e_tovf_r, 2'h0, ev_eid_r, cnt_r}); // R16
        end
        default: ;
      endcase
    end
  end

  // The error word waits for room; hits meanwhile are lost, not queued.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      cerr_r <= 1'b0;
    else
      cerr_r <= full_ev | (cerr_r & of_full);
  end

  logic [31:0] of_mem [2**OF_AW];
  logic [OF_AW:0] of_wp_r, of_rp_r;
  logic        out_valid_r;
  logic [31:0] out_data_r;
  wire of_empty = of_wp_r == of_rp_r;
  assign of_full = of_wp_r == {~of_rp_r[OF_AW], of_rp_r[OF_AW-1:0]};
  wire of_pop = !of_empty && (!out_valid_r || out_ready_i);
  always_ff @(posedge clk_i) begin
    if (of_push)
      of_mem[of_wp_r[OF_AW-1:0]] <= of_word;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      of_wp_r     <= '0;
      of_rp_r     <= '0;
      out_valid_r <= 1'b0;
      out_data_r  <= 32'h0;
    end else begin
      if (of_push)
        of_wp_r <= of_wp_r + (OF_AW+1)'(1);
      if (of_pop) begin
        of_rp_r    <= of_rp_r + (OF_AW+1)'(1);
        out_data_r <= of_mem[of_rp_r[OF_AW-1:0]];
      end
      if (of_pop)
        out_valid_r <= 1'b1;
      else if (out_ready_i)
        out_valid_r <= 1'b0;
    end
  end

  assign prdata_o    = prdata_r;
  assign pready_o    = pready_r;
  assign pslverr_o   = pslverr_r;
  assign out_valid_o = out_valid_r;
  assign out_data_o  = out_data_r;
  assign full_o      = full_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  tick_space_a: assert property (tick_r |=> !tick_r [*5]) // R5
    else $error("tick came too early");
  trig_delay_a: assert property (start_ev |=> // R7
    st_r == ST_SCAN && tag_r - ev_tag_r >= `TDCM_TRIG_DELAY)
    else $error("trigger matched before its delay");
  cont_data_a: assert property (!trig_mode && of_push |-> // R1
    of_word[31:27] inside {`TDCM_W_DATA, `TDCM_W_ERR})
    else $error("control word in continuous mode");
  cont_full_a: assert property (full_ev |=> full_r ##1 (full_r || $past(st_clr))) // R3
    else $error("full flag not set on overflow");
  reject_idle_a: assert property ($changed(rp_r) |-> // R9
    $past(tf_empty) && $past(st_r) == ST_IDLE)
    else $error("hit rejected while trigger pending");
  hit_limit_a: assert property (limit_r != 8'h00 && st_r == ST_SCAN |-> lim_r <= limit_r) // R13
    else $error("hit limit exceeded");
  long_trigger_timestamp_latch_a: assert property (tf_push |=> tf_ett[$past(tf_wi)] == $past(long_trigger_timestamp_r)) // R21
    else $error("timestamp not latched with trigger");
  bunch_reset_a: assert property (bcr_i |=> // R23
    tag_r == $past(toff_r) && coarse_r == $past(coff_r))
    else $error("bunch reset did not load offsets");
  event_reset_a: assert property (ecr_i |=> evid_r == $past(eoff_r)) // R24
    else $error("event reset did not load offset");
  trail_full_a: assert property (st_r == ST_TRAIL && of_push |-> // R16
    of_word[26] == (e_hovf_r | e_tovf_r))
    else $error("trailer full bit wrong");
  match_win_a: assert property (st_r == ST_SCAN && of_push && !need_hdr && !need_ett |-> // R4
    diff < win_w_r)
    else $error("hit outside window reported");

  ev_framed_c: cover property (st_r == ST_SCAN ##[1:200] st_r == ST_TRAIL && of_push);
  cont_ovf_c:  cover property (full_ev ##[1:50] (cerr_r && of_push));
  suppress_c:  cover property (st_r == ST_FLUSH && cnt_r == 12'h0 ##1 st_r == ST_IDLE);

endmodule : tdcm_match
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the hit trigger matching block.
`default_nettype none
`include "tdcm_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb;
  import tdcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, arst_n_i = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, out_ready = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, out_data, q, w1, w2;
  logic        pready, pslverr, hit_valid, trig, bcr, ecr, out_valid, full, e, saw;
  logic [4:0]  hit_chan;
  logic [9:0]  hit_fine;
  int          n_errors = 0, samples_checked = 0, cyc = 0;
  always #2 clk_i = ~clk_i;
  tdcm_src u_tdcm_src (.clk_i(clk_i), .hit_valid_o(hit_valid), .hit_chan_o(hit_chan),
    .hit_fine_o(hit_fine), .trig_o(trig), .bcr_o(bcr), .ecr_o(ecr));
  tdcm_match u_tdcm_match (.clk_i(clk_i), .arst_n_i(arst_n_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .hit_valid_i(hit_valid),
    .hit_chan_i(hit_chan), .hit_fine_i(hit_fine), .trig_i(trig), .bcr_i(bcr), .ecr_i(ecr),
    .out_valid_o(out_valid), .out_data_o(out_data), .out_ready_i(out_ready), .full_o(full));
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  // The request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin n_errors++; $display("ERROR %0t no pready", $time); end
  endtask : apb
  // Ready is raised only while a word is wanted, so words stand until taken.
  task automatic take(output logic [31:0] w);
    int n;
    n = 0;
    @(posedge clk_i);
    out_ready <= 1'b1;
    do begin @(posedge clk_i); n++; end while (out_valid !== 1'b1 && n < 4000);
    w = out_data;
    out_ready <= 1'b0;
    if (n >= 4000) begin n_errors++; $display("ERROR %0t no word", $time); end
  endtask : take
  task automatic t_regs;
    apb(1'b0, `TDCM_A_WIN, 32'h0);
    `CHK(q, {4'h0, `TDCM_RST_OFFSET, 4'h0, `TDCM_RST_WIDTH})
    apb(1'b0, `TDCM_A_MARGIN, 32'h0);
    `CHK(q, {4'h0, `TDCM_RST_REJECT, 4'h0, `TDCM_RST_EXTRA})
    apb(1'b0, 8'h40, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0})
    $display("test regs done");
  endtask : t_regs
  task automatic t_cont;
    apb(1'b1, `TDCM_A_CTRL, 32'h0);
    u_tdcm_src.hits(5'd3, 1);
    repeat (8) @(posedge clk_i);
    u_tdcm_src.hits(5'd9, 1);
    take(w1);
    `CHK(w1[31:21], 11'h003)
    take(w2);
    `CHK(w2[31:21], 11'h009)
    `CHK(w2[20:0] > w1[20:0], 1'b1)
    $display("test continuous done");
  endtask : t_cont
  task automatic t_ovf;
    u_tdcm_src.hits(5'd1, 300);
    @(posedge clk_i);
    `CHK(full, 1'b1)
    apb(1'b0, `TDCM_A_STATUS, 32'h0);
    `CHK(q[0], 1'b1)
    out_ready <= 1'b1;
    saw = 1'b0;
    repeat (600) begin
      @(posedge clk_i);
      if (out_valid === 1'b1 && out_data[31:27] == `TDCM_W_ERR) saw = 1'b1;
    end
    out_ready <= 1'b0;
    `CHK(saw, 1'b1)
    apb(1'b1, `TDCM_A_STATUS, 32'h1);
    @(posedge clk_i);
    `CHK(full, 1'b0)
    $display("test overflow done");
  endtask : t_ovf
  task automatic t_trig;
    // A wide reject margin keeps the early hit alive until its trigger is seen.
    apb(1'b1, `TDCM_A_MARGIN, 32'h0040_0008);
    // Window of 20 cycles ending 20 cycles before the trigger.
    apb(1'b1, `TDCM_A_WIN, 32'h0fd8_0014);
    apb(1'b1, `TDCM_A_EOFFS, 32'h5);
    u_tdcm_src.pulse(1);
    u_tdcm_src.pulse(2);
    apb(1'b1, `TDCM_A_CTRL, 32'h7);
    u_tdcm_src.hits(5'd4, 1);
    repeat (190) @(posedge clk_i);
    u_tdcm_src.pulse(0);
    repeat (25) @(posedge clk_i);
    u_tdcm_src.pulse(0);
    for (int k = 0; k < 2; k++) begin
      take(w1);
      `CHK({w1[31:27], w1[23:12]}, {`TDCM_W_HEAD, 12'h005 + 12'(k)})
      take(w1);
      `CHK(w1[31:21], 11'h004)
      take(w2);
      `CHK({w2[31:27], w2[11:0]}, {`TDCM_W_TRAIL, 12'h001})
    end
    $display("test trigger done");
  endtask : t_trig
  // Straddling window, relative time, timestamp word, limit of one hit and
  // suppression: the second trigger's window holds no hit at all.
  task automatic t_win;
    apb(1'b1, `TDCM_A_WIN, 32'h0ff6_0014);
    apb(1'b1, `TDCM_A_LIMIT, 32'h1);
    apb(1'b1, `TDCM_A_CTRL, 32'h3f);
    u_tdcm_src.pulse(0);
    u_tdcm_src.hits(5'd6, 1);
    u_tdcm_src.hits(5'd7, 1);
    repeat (200) @(posedge clk_i);
    u_tdcm_src.pulse(0);
    take(w1);
    `CHK({w1[31:27], w1[23:12]}, {`TDCM_W_HEAD, 12'h007})
    take(w1);
    `CHK(w1[31:27], `TDCM_W_LONG_TRIGGER_TIMESTAMP)
    take(w1);
    `CHK({w1[31:21], w1[20:11]}, {11'h006, 10'h005})
    take(w1);
    `CHK(w1, {`TDCM_W_ERR, 27'h8})
    take(w1);
    `CHK({w1[31:26], w1[11:0]}, {`TDCM_W_TRAIL, 1'b0, 12'h001})
    repeat (400) @(posedge clk_i);
    `CHK(out_valid, 1'b0)
    $display("test window done");
  endtask : t_win
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_cont();
    t_ovf();
    t_trig();
    t_win();
    summarize();
  end
endmodule : tb
`default_nettype wire

// >>> tb/tdcm_src.sv
// Source model for detector hits, triggers and the two counter resets.
`default_nettype none
module tdcm_src (
  input  wire logic       clk_i,
  output logic            hit_valid_o,
  output logic      [4:0] hit_chan_o,
  output logic      [9:0] hit_fine_o,
  output logic            trig_o,
  output logic            bcr_o,
  output logic            ecr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hit_valid_o = 1'b0;
    hit_chan_o  = 5'h00;
    hit_fine_o  = 10'h000;
    trig_o      = 1'b0;
    bcr_o       = 1'b0;
    ecr_o       = 1'b0;
  end
  // Fine bins move every cycle so that a stale value is never mistaken for a hit.
  always @(posedge clk_i) begin
    hit_fine_o <= hit_fine_o + 10'h001;
  end
  // A burst holds valid high for n cycles; the channel is inverted once released.
  task automatic hits(input logic [4:0] ch, input int n);
    @(posedge clk_i);
    hit_valid_o <= 1'b1;
    hit_chan_o  <= ch;
    repeat (n) @(posedge clk_i);
    hit_valid_o <= 1'b0;
    hit_chan_o  <= ~ch;
  endtask : hits
  // Pulses: 0 trigger, 1 bunch reset, 2 event reset; callers keep triggers 4 ticks apart.
  task automatic pulse(input int sel);
    @(posedge clk_i);
    trig_o <= (sel == 0);
    bcr_o  <= (sel == 1);
    ecr_o  <= (sel == 2);
    @(posedge clk_i);
    {trig_o, bcr_o, ecr_o} <= 3'h0;
  endtask : pulse
endmodule : tdcm_src
`default_nettype wire
